// >>> logic/irqc_defs.vh
// Constants for the interrupt response and external irq block.
// Assumes inclusion by the single design file only.
`ifndef IRQC_DEFS_VH
`define IRQC_DEFS_VH

// Register byte offsets
`define IRQC_OFS_CORE_CTRL 8'h00
`define IRQC_OFS_SENSE 8'h04
`define IRQC_OFS_FLAGS 8'h08
`define IRQC_OFS_MASK0 8'h0C
`define IRQC_OFS_MASK1 8'h10
`define IRQC_OFS_MASK2 8'h14
`define IRQC_OFS_MASK3 8'h18
`define IRQC_OFS_STATUS 8'h1C

// core_control_register fields
`define IRQC_CC_VECTOR_TABLE_SELECT 0
`define IRQC_CC_GIE 1
`define IRQC_CC_RESET 2'b00

// external_irq_sense_control fields
`define IRQC_SC_MODE_LO 0
`define IRQC_SC_MODE_HI 1
`define IRQC_SC_EN 2
`define IRQC_SC_PCEN_LO 3
`define IRQC_SC_PCEN_HI 6
`define IRQC_SC_RESET 7'h00

// Sense modes
`define IRQC_MODE_LOW 2'b00
`define IRQC_MODE_ANY 2'b01
`define IRQC_MODE_FALL 2'b10
`define IRQC_MODE_RISE 2'b11

// Flag register: bit 0 external pin, bits 4:1 pin-change groups
`define IRQC_FLAGS_RESET 5'h00
`define IRQC_MASK_RESET 8'h00

// Vector layout, word addresses
`define IRQC_VEC_STRIDE 16'h0002
`define IRQC_NSRC 5

// Bus responses
`define IRQC_RESP_OKAY 2'b00
`define IRQC_RESP_SLVERR 2'b10

`endif

// >>> logic/irqc_top.v
// Interrupt response logic with external pin and pin-change sources.
// Assumes the core pulses its strobes for one cycle and that pin
// inputs are already synchronous to aclk.
`include "irqc_defs.vh"

////////////////////////////////////////////////////////////////////////
// How it works
// - Reset outranks all; the external pin outranks every other source.
// - Vector select bit moves the vector table to the boot section.
// - Taking any interrupt clears the global enable.
// - Setting global enable inside a handler allows nesting.
// - Return-from-handler sets the global enable again.
// - Taking a flag request vectors and clears that flag.
// - Writing one to a flag clears it; zero leaves it.
// - Flags set while disabled stay pending until enabled or cleared.
// - Pending flags are served one by one in priority order.
// - Level requests exist only while the condition is present.
// - After a return, one main instruction runs before the next take.
// - Status register is neither saved nor restored by hardware.
// - Disable strobe blocks a take in the very same cycle.
// - Pins driven as outputs still trigger interrupts.
// - Group one watches sources 15..8, group zero 7..0.
// - Four mask registers select contributing pins bit by bit.
// - Pin changes are seen without a clock to wake the device.
// - External pin senses falling edge, rising edge, any edge or low level.
// - Low level keeps requesting while the pin stays low.
// - Edges need the I/O clock, which stops outside idle.
// - Low level is seen without a clock for wake-up.
// - A low level gone before start-up ends wakes but never interrupts.
module irqc_top #(
  parameter [15:0] BOOT_START = 16'h1000
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire core_boundary,
  input wire core_return_from_handler,
  input wire core_disable_irq_instruction,
  input wire core_enable_irq_instruction,
  input wire io_clk_running,
  input wire dedicated_external_irq_pin,
  input wire [30:0] pin_change_sources,
  output reg irq_take,
  output reg [15:0] irq_vector,
  output reg global_irq_enable,
  output wire wake_request
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  function [2:0] irqc_first;
    input [`IRQC_NSRC-1:0] req;
    integer i;
    begin
      irqc_first = 3'd7;
      for (i = `IRQC_NSRC - 1; i >= 0; i = i - 1) begin
        if (req[i]) begin
          irqc_first = i[2:0];
        end
      end
    end
  endfunction

  function irqc_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      irqc_hit = (addr[7:2] == ofs[7:2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State

  reg vector_table_select_q;
  reg [6:0] sense_q;
  reg [`IRQC_NSRC-1:0] flags_q;
  reg [`IRQC_NSRC-1:0] flags_d;
  reg [31:0] mask_q;
  reg [31:0] pin_last_q;
  reg ext_last_q;
  reg one_insn_q;
  reg aw_full_q;
  reg w_full_q;
  reg [7:0] aw_addr_q;
  reg [31:0] w_data_q;
  reg [3:0] w_strb_q;

  wire [31:0] pins = {1'b0, pin_change_sources};
  wire [1:0] mode = sense_q[`IRQC_SC_MODE_HI:`IRQC_SC_MODE_LO];
  wire ext_en = sense_q[`IRQC_SC_EN];
  wire [3:0] pc_en = sense_q[`IRQC_SC_PCEN_HI:`IRQC_SC_PCEN_LO];
  wire ext_low_mode = (mode == `IRQC_MODE_LOW);

  ////////////////////////////////////////////////////////////////////
  // Source detection

  // Pin levels are pad levels, so a pin driven as output still fires
  wire [31:0] pin_chg = (pins ^ pin_last_q) & mask_q;
  wire [3:0] grp_chg;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : grp
      assign grp_chg[g] = |pin_chg[g*8+7:g*8];
    end
  endgenerate

  // Edges only count while the I/O clock runs
  wire ext_fall = ext_last_q & ~dedicated_external_irq_pin;
  wire ext_rise = ~ext_last_q & dedicated_external_irq_pin;
  reg ext_edge;
  always @* begin
    case (mode)
      `IRQC_MODE_FALL: ext_edge = ext_fall;
      `IRQC_MODE_RISE: ext_edge = ext_rise;
      `IRQC_MODE_ANY: ext_edge = ext_fall | ext_rise;
      default: ext_edge = 1'b0;
    endcase
  end
  wire ext_set = ext_edge & io_clk_running;

  // Low level is a live condition with no flag behind it
  wire ext_level_req = ext_en & ext_low_mode &
    ~dedicated_external_irq_pin;

  // Clockless wake paths: pure gates on pins and stored state
  assign wake_request = (|pin_chg) | ext_level_req;

  ////////////////////////////////////////////////////////////////////
  // Request selection

  wire [`IRQC_NSRC-1:0] req = {
    pc_en & flags_q[4:1],
    ext_low_mode ? ext_level_req : (ext_en & flags_q[0])
  };
  wire [2:0] pick = irqc_first(req);

  // Disable strobe in the same cycle wins over a take
  wire take = core_boundary & global_irq_enable & (|req) &
    ~one_insn_q & ~core_disable_irq_instruction;

  wire [15:0] vec_base = vector_table_select_q ? BOOT_START : 16'h0000;
  wire [15:0] vec_ofs = ({13'd0, pick} + 16'd1) * `IRQC_VEC_STRIDE;

  ////////////////////////////////////////////////////////////////////
  // Bus write decode

  wire wr_fire = aw_full_q & w_full_q & ~s_axi_bvalid;
  wire wr_lane = wr_fire & w_strb_q[0];
  wire wr_cc = wr_lane & irqc_hit(aw_addr_q, `IRQC_OFS_CORE_CTRL);
  wire wr_sc = wr_lane & irqc_hit(aw_addr_q, `IRQC_OFS_SENSE);
  wire wr_fl = wr_lane & irqc_hit(aw_addr_q, `IRQC_OFS_FLAGS);
  wire wr_mapped = aw_addr_q < 8'h20;

  wire [3:0] wr_mask;
  generate
    for (g = 0; g < 4; g = g + 1) begin : mwr
      assign wr_mask[g] = wr_lane &
        (aw_addr_q[7:2] == (`IRQC_OFS_MASK0 >> 2) + g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Flags: set beats both clears

  reg [`IRQC_NSRC-1:0] set_v;
  reg [`IRQC_NSRC-1:0] hw_clr;
  always @* begin
    set_v = {grp_chg, ext_set & ~ext_low_mode};
    hw_clr = {`IRQC_NSRC{1'b0}};
    if (take) begin
      hw_clr[pick] = 1'b1;
    end
    flags_d = flags_q;
    if (wr_fl) begin
      flags_d = flags_d & ~w_data_q[`IRQC_NSRC-1:0];
    end
    flags_d = (flags_d & ~hw_clr) | set_v;
  end

  ////////////////////////////////////////////////////////////////////
  // Core-side sequencing

  // Only the enable bit moves; the rest of the status word is software's
  always @(posedge aclk) begin
    if (!aresetn) begin
      global_irq_enable <= 1'b0;
      one_insn_q <= 1'b0;
      irq_take <= 1'b0;
      irq_vector <= 16'h0000;
    end else begin
      irq_take <= take;
      if (take) begin
        irq_vector <= vec_base + vec_ofs;
      end
      if (core_return_from_handler) begin
        one_insn_q <= 1'b1;
      end else if (core_boundary) begin
        one_insn_q <= 1'b0;
      end
      if (take | core_disable_irq_instruction) begin
        global_irq_enable <= 1'b0;
      end else if (core_return_from_handler) begin
        global_irq_enable <= 1'b1;
      end else if (core_enable_irq_instruction) begin
        global_irq_enable <= 1'b1;
      end else if (wr_cc) begin
        global_irq_enable <= w_data_q[`IRQC_CC_GIE];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Source registers

  always @(posedge aclk) begin
    if (!aresetn) begin
      vector_table_select_q <= 1'b0;
      sense_q <= `IRQC_SC_RESET;
      flags_q <= `IRQC_FLAGS_RESET;
      mask_q <= 32'h0000_0000;
      pin_last_q <= 32'h0000_0000;
      ext_last_q <= 1'b1;
    end else begin
      flags_q <= flags_d;
      pin_last_q <= pins;
      // Edge history freezes with the I/O clock
      if (io_clk_running) begin
        ext_last_q <= dedicated_external_irq_pin;
      end
      if (wr_cc) begin
        vector_table_select_q <= w_data_q[`IRQC_CC_VECTOR_TABLE_SELECT];
      end
      if (wr_sc) begin
        sense_q <= w_data_q[6:0];
      end
    end
  end

  generate
    for (g = 0; g < 4; g = g + 1) begin : mreg
      always @(posedge aclk) begin
        if (!aresetn) begin
          mask_q[g*8+7:g*8] <= `IRQC_MASK_RESET;
        end else if (wr_mask[g]) begin
          mask_q[g*8+7:g*8] <= w_data_q[7:0];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel

  assign s_axi_awready = ~aw_full_q;
  assign s_axi_wready = ~w_full_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IRQC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & ~aw_full_q) begin
        aw_full_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & ~w_full_q) begin
        w_full_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? `IRQC_RESP_OKAY : `IRQC_RESP_SLVERR;
      end
      // Slots free only once the answer is taken
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel

  reg [31:0] rd_word;
  reg rd_ok;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr[7:2])
      `IRQC_OFS_CORE_CTRL >> 2: rd_word[1:0] =
        {global_irq_enable, vector_table_select_q};
      `IRQC_OFS_SENSE >> 2: rd_word[6:0] = sense_q;
      `IRQC_OFS_FLAGS >> 2: rd_word[`IRQC_NSRC-1:0] = flags_q;
      `IRQC_OFS_MASK0 >> 2: rd_word[7:0] = mask_q[7:0];
      `IRQC_OFS_MASK1 >> 2: rd_word[7:0] = mask_q[15:8];
      `IRQC_OFS_MASK2 >> 2: rd_word[7:0] = mask_q[23:16];
      `IRQC_OFS_MASK3 >> 2: rd_word[7:0] = mask_q[31:24];
      `IRQC_OFS_STATUS >> 2: rd_word[3:0] = {one_insn_q,
        wake_request, io_clk_running, dedicated_external_irq_pin};
      default: rd_ok = 1'b0;
    endcase
  end

  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `IRQC_RESP_OKAY;
    end else if (s_axi_arvalid & ~s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? `IRQC_RESP_OKAY : `IRQC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

// >>> tb/irqc_props.sv
// Assertions on the core side and the read channel of the interrupt block.
// Assumes binding onto irqc_top, which hands on its parameter.
module irqc_props #(
  parameter [15:0] BOOT_START = 16'h1000
) (
  input wire aclk,
  input wire aresetn,
  input wire core_boundary,
  input wire core_return_from_handler,
  input wire core_disable_irq_instruction,
  input wire global_irq_enable,
  input wire irq_take,
  input wire [15:0] irq_vector,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////
  chk_take_gie: assert property (irq_take |-> !global_irq_enable)
    else $error("enable left set after take");
  chk_take_cause: assert property (irq_take |->
    $past(core_boundary) && $past(global_irq_enable))
    else $error("take without boundary and enable");
  chk_ret_gie: assert property (core_return_from_handler &&
    !core_disable_irq_instruction |=> global_irq_enable)
    else $error("return left enable clear");
  chk_cli_block: assert property (core_disable_irq_instruction |=>
    !irq_take && !global_irq_enable)
    else $error("take after disable");
  chk_ret_window: assert property (core_return_from_handler
    ##1 core_boundary |=> !irq_take)
    else $error("take inside return window");
  chk_vec_range: assert property (irq_take |-> !irq_vector[0] &&
    (irq_vector & ~BOOT_START) inside {[16'h0002:16'h000A]})
    else $error("vector outside table");
  chk_take_pulse: assert property (irq_take |=> !irq_take)
    else $error("take longer than a cycle");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
endmodule

bind irqc_top irqc_props #(.BOOT_START(BOOT_START)) u_irqc_props (
  .aclk(aclk), .aresetn(aresetn), .core_boundary(core_boundary),
  .core_return_from_handler(core_return_from_handler),
  .core_disable_irq_instruction(core_disable_irq_instruction),
  .global_irq_enable(global_irq_enable), .irq_take(irq_take),
  .irq_vector(irq_vector), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));

// >>> tb/irqc_core_model.sv
// Core sequencer model: instruction boundaries and handler returns.
// Assumes irq_take comes from the block on the same clock.
module irqc_core_model (
  input wire aclk,
  input wire aresetn,
  input wire run,
  input wire [3:0] hlen,
  input wire irq_take,
  output wire core_boundary,
  output wire core_return_from_handler
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ret_q = 1'b0;
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] depth_q = 4'h0;
  //////////////////////////////////////////////////////////////////
  // Return cycle is never a boundary, as the block expects
  assign core_return_from_handler = ret_q;
  assign core_boundary = run && !ret_q && aresetn;
  always @(posedge aclk) begin
    ret_q <= 1'b0;
    if (!aresetn) begin
      depth_q <= 4'h0;
    end else if (irq_take) begin
      depth_q <= depth_q + 4'h1;
      cnt_q <= hlen;
    end else if (depth_q != 4'h0) begin
      cnt_q <= (cnt_q == 4'h0) ? hlen : cnt_q - 4'h1;
      if (cnt_q == 4'h0) begin
        ret_q <= 1'b1;
        depth_q <= depth_q - 4'h1;
      end
    end
  end
endmodule

// >>> tb/tb.sv
// Bench for irqc_top: register bus, pins and the core model.
// Assumes the checker binds itself onto the design.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0, en_s = 0, dis_s = 0, ioclk = 1;
  logic xpin = 1, run = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0;
  logic [30:0] pcs = 0;
  logic [3:0] hlen = 0;
  logic [2:0] r, prot = 0;
  logic [3:0] strb = 4'hF;
  wire awready, wready, bvalid, arready, rvalid, bnd, ret, take, gie, wake;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] vec;
  int error_cnt = 0, checked = 0, n_take = 0;
  logic [15:0] q_vec[$];
  logic [33:0] q_rd[$];
  always #25 aclk = ~aclk;
  irqc_top u_irqc_top (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awprot(prot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(prot),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .core_boundary(bnd), .core_return_from_handler(ret),
    .core_disable_irq_instruction(dis_s), .core_enable_irq_instruction(en_s),
    .io_clk_running(ioclk), .dedicated_external_irq_pin(xpin),
    .pin_change_sources(pcs), .irq_take(take), .irq_vector(vec),
    .global_irq_enable(gie), .wake_request(wake));
  irqc_core_model u_irqc_core_model (.aclk(aclk), .aresetn(aresetn),
    .run(run), .hlen(hlen), .irq_take(take), .core_boundary(bnd),
    .core_return_from_handler(ret));
  //////////////////////////////////////////////////////////////////
  task automatic check(input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic finish_test();
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wr(input [7:0] a, input [7:0] d, input [1:0] e = 2'h0);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40 && bvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (n == 40) error_cnt++;
    if (n == 40) finish_test();
    check(bresp, e);
    bready <= 1'b0;
  endtask
  task automatic rd(input [7:0] a, input [33:0] e);
    int n;
    @(posedge aclk);
    q_rd.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40 && rvalid !== 1'b1; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    if (n == 40) error_cnt++;
    if (n == 40) finish_test();
    rready <= 1'b0;
  endtask
  task automatic wait_take(input int t);
    int n;
    for (n = 0; n < 200 && n_take < t; n++) @(posedge aclk);
    if (n_take < t) error_cnt++;
    if (n_take < t) finish_test();
  endtask
  // With the queue empty, an unexpected take is checked against 16'h0001, which no vector matches
  always @(posedge aclk) begin
    if (rvalid === 1'b1 && rready === 1'b1)
      check({rresp, rdata}, q_rd.size() ? q_rd.pop_front() : 34'h1);
    if (take === 1'b1) begin
      n_take++;
      check(vec, q_vec.size() ? q_vec.pop_front() : 16'h0001);
    end
  end
  //////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(66));
    r = $urandom_range(7);
    prot <= $urandom_range(7);
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    run <= 1'b1;
    rd(8'h04, 34'h0);
    rd(8'h20, {2'h2, 32'h0000_0000});
    wr(8'h24, 8'hFF, 2'h2);
    wr(8'h04, 8'h06);
    @(posedge aclk) xpin <= 1'b0;
    rd(8'h08, 34'h1);
    q_vec.push_back(16'h0002);
    wr(8'h00, 8'h02);
    wait_take(1);
    rd(8'h08, 34'h0);
    hlen <= 4'h5;
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h0E);
    wr(8'h0C, 8'hFF);
    // Low byte lane off: the write must change nothing
    strb <= 4'hE;
    wr(8'h0C, 8'h00);
    strb <= 4'hF;
    rd(8'h0C, 34'hFF);
    @(posedge aclk) xpin <= 1'b1;
    @(posedge aclk) xpin <= 1'b0;
    pcs[r] <= 1'b1;
    rd(8'h08, 34'h3);
    q_vec.push_back(16'h1002);
    q_vec.push_back(16'h1004);
    wr(8'h00, 8'h03);
    wait_take(3);
    repeat (10) @(posedge aclk);
    wr(8'h00, 8'h01);
    wr(8'h10, 8'h01 << r);
    @(posedge aclk) pcs[r+8] <= 1'b1;
    pcs[r+9] <= 1'b1;
    rd(8'h08, 34'h4);
    wr(8'h08, 8'h00);
    rd(8'h08, 34'h4);
    wr(8'h08, 8'h04);
    rd(8'h08, 34'h0);
    @(posedge aclk) xpin <= 1'b1;
    @(posedge aclk) xpin <= 1'b0;
    en_s <= 1'b1;
    @(posedge aclk) en_s <= 1'b0;
    dis_s <= 1'b1;
    @(posedge aclk) dis_s <= 1'b0;
    rd(8'h08, 34'h1);
    wr(8'h08, 8'h01);
    wr(8'h04, 8'h04);
    check(wake, 1'b1);
    @(posedge aclk) xpin <= 1'b1;
    en_s <= 1'b1;
    @(posedge aclk) en_s <= 1'b0;
    repeat (5) @(posedge aclk);
    q_vec.push_back(16'h1002);
    q_vec.push_back(16'h1002);
    xpin <= 1'b0;
    wait_take(5);
    xpin <= 1'b1;
    repeat (10) @(posedge aclk);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h07);
    @(posedge aclk) xpin <= 1'b0;
    ioclk <= 1'b0;
    @(posedge aclk) xpin <= 1'b1;
    rd(8'h08, 34'h0);
    @(posedge aclk) xpin <= 1'b0;
    @(posedge aclk) ioclk <= 1'b1;
    @(posedge aclk) xpin <= 1'b1;
    rd(8'h08, 34'h1);
    check(q_vec.size(), 34'h0);
    finish_test();
  end
endmodule
